// >>> ivfr_input_supervisor.sv
// Input-voltage threshold registers, status reporting and undervoltage fault sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ivfr_defines.svh"

// Overview of operation
// - Command 0x57 is a read/write 16-bit high input warning threshold.
// - Command 0x58 is a read/write 16-bit low input warning threshold.
// - Command 0x59 is a read/write 16-bit low input fault threshold.
// - Command 0x5A byte: mode in 7:6, retry count 5:3, delay 2:0.
// - Any low input fault pulls the alert line low and sets status.
// - Mode 00 keeps the output running through the fault.
// - Mode 01 runs for the delay, then applies retry setting if fault remains.
// - Mode 10 disables the output at once, then applies retry setting.
// - Mode 11 holds output off while fault persists, re-enables when gone.
// - Retry code 000: no restart, output stays off until fault cleared.
// - Retry codes 001 to 110 restart one to six times, then stay off.
// - Retry code 111 restarts forever until commanded off or another fault.
// - Continue delay is the delay field times ten milliseconds.
// - Restart attempts start the delay field times 8.2 ms apart.
// - Status byte bit 3 reports the latched low input fault.
// - Status word bit 13 shows any input fault or warning present.
module ivfr_input_supervisor
  import ivfr_pkg::*;
#(
  parameter int unsigned CONT_UNIT_CYC = `IVFR_CONT_UNIT_US * `IVFR_CLK_MHZ,
  parameter int unsigned RETRY_UNIT_CYC = `IVFR_RETRY_UNIT_US * `IVFR_CLK_MHZ
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Command port
  input wire logic CMD_WR_IN,
  input wire logic CMD_RD_IN,
  input wire logic [7:0] CMD_CODE_IN,
  input wire logic [15:0] CMD_WDATA_IN,
  output logic [15:0] CMD_RDATA_OUT,
  output logic CMD_RVALID_OUT,
  output logic CMD_ERR_OUT,
  // Power stage control and measurement
  input wire logic [15:0] VIN_VALUE_IN,
  input wire logic OUTPUT_ON_IN,
  input wire logic OTHER_FAULT_OFF_IN,
  input wire logic CLEAR_FAULTS_IN,
  output logic OUTPUT_ENABLE_OUT,
  // Open-drain alert line
  output logic ALERT_LINE_N_OUT,
  output logic ALERT_LINE_N_OE_N_OUT
);

  ivfr_core_if core_if ();

  logic [15:0] hi_warn_thr_r;
  logic [15:0] lo_warn_thr_r;
  logic [15:0] lo_fault_thr_r;
  logic [7:0] reaction_r;

  ivfr_state_t state_r;
  logic out_en_r;
  logic [2:0] tries_r;
  logic tmr_start_r;
  logic tmr_retry_r;

  logic lo_fault_lat_r;
  logic warn_lat_r;
  logic alert_n_r;

  logic [15:0] rdata_r;
  logic rvalid_r;
  logic err_r;

  ivfr_mode_t mode;
  logic [2:0] retry_set;
  logic [2:0] delay_units;
  logic lo_fault;
  logic any_warn;
  logic [7:0] stat_byte;
  logic [15:0] stat_word;
  logic code_known;
  logic code_writable;
  logic [2:0] tries_inc;
  logic retries_spent;
  logic tmr_fresh_done;

  // Field split of the reaction byte
  assign mode = ivfr_mode_t'(reaction_r[`IVFR_MODE_MSB:`IVFR_MODE_LSB]);
  assign retry_set = reaction_r[`IVFR_RETRY_MSB:`IVFR_RETRY_LSB];
  assign delay_units = reaction_r[`IVFR_DELAY_MSB:`IVFR_DELAY_LSB];

  // Monitor and timer wiring
  assign core_if.vin = VIN_VALUE_IN;
  assign core_if.thr[`IVFR_CH_HI_WARN] = hi_warn_thr_r;
  assign core_if.thr[`IVFR_CH_LO_WARN] = lo_warn_thr_r;
  assign core_if.thr[`IVFR_CH_LO_FAULT] = lo_fault_thr_r;
  assign core_if.tmr_start = tmr_start_r;
  assign core_if.tmr_retry = tmr_retry_r;
  assign core_if.tmr_units = delay_units;

  assign lo_fault = core_if.hit[`IVFR_CH_LO_FAULT];
  assign any_warn = core_if.hit[`IVFR_CH_HI_WARN] | core_if.hit[`IVFR_CH_LO_WARN];

  ivfr_vin_monitor u_monitor (
    .clk(SYS_CLK_IN),
    .rst(RST_IN),
    .mon(core_if.mon)
  );

  ivfr_delay_timer #(
    .CONT_CYC(CONT_UNIT_CYC),
    .RETRY_CYC(RETRY_UNIT_CYC)
  ) u_timer (
    .clk(SYS_CLK_IN),
    .rst(RST_IN),
    .tmr(core_if.tmr)
  );

  // Status views
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`IVFR_SB_OFF] = ~out_en_r;
    stat_byte[`IVFR_SB_LO_FAULT] = lo_fault_lat_r;
    stat_byte[`IVFR_SB_OTHER] = warn_lat_r;
    stat_word = {8'h00, stat_byte};
    // Live and latched both count, so a cleared-but-present fault still shows
    stat_word[`IVFR_SW_INPUT] = lo_fault_lat_r | warn_lat_r | lo_fault | any_warn;
  end

  always_comb begin
    code_writable = (CMD_CODE_IN == `IVFR_CMD_HI_WARN) || (CMD_CODE_IN == `IVFR_CMD_LO_WARN) ||
                    (CMD_CODE_IN == `IVFR_CMD_LO_FAULT) || (CMD_CODE_IN == `IVFR_CMD_REACTION);
    code_known = code_writable || (CMD_CODE_IN == `IVFR_CMD_STAT_BYTE) ||
                 (CMD_CODE_IN == `IVFR_CMD_STAT_WORD);
  end

  // Threshold and reaction writes
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hi_warn_thr_r <= `IVFR_RST_THR;
      lo_warn_thr_r <= `IVFR_RST_THR;
      lo_fault_thr_r <= `IVFR_RST_THR;
      reaction_r <= `IVFR_RST_REACTION;
    end else if (CMD_WR_IN) begin
      unique case (CMD_CODE_IN)
        `IVFR_CMD_HI_WARN: hi_warn_thr_r <= CMD_WDATA_IN;
        `IVFR_CMD_LO_WARN: lo_warn_thr_r <= CMD_WDATA_IN;
        `IVFR_CMD_LO_FAULT: lo_fault_thr_r <= CMD_WDATA_IN;
        `IVFR_CMD_REACTION: reaction_r <= CMD_WDATA_IN[7:0];
        default: begin
        end
      endcase
    end
  end

  // Read-back, one cycle after the request
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= CMD_RD_IN;
      if (CMD_RD_IN) begin
        unique case (CMD_CODE_IN)
          `IVFR_CMD_HI_WARN: rdata_r <= hi_warn_thr_r;
          `IVFR_CMD_LO_WARN: rdata_r <= lo_warn_thr_r;
          `IVFR_CMD_LO_FAULT: rdata_r <= lo_fault_thr_r;
          `IVFR_CMD_REACTION: rdata_r <= {8'h00, reaction_r};
          `IVFR_CMD_STAT_BYTE: rdata_r <= {8'h00, stat_byte};
          `IVFR_CMD_STAT_WORD: rdata_r <= stat_word;
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // Unknown codes and writes to status codes are flagged, never stored
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      err_r <= 1'b0;
    end else begin
      err_r <= (CMD_WR_IN && !code_writable) || (CMD_RD_IN && !code_known);
    end
  end

  // Latched fault and warning flags; a new event beats a clear
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      lo_fault_lat_r <= 1'b0;
      warn_lat_r <= 1'b0;
    end else begin
      if (lo_fault) begin
        lo_fault_lat_r <= 1'b1;
      end else if (CLEAR_FAULTS_IN) begin
        lo_fault_lat_r <= 1'b0;
      end
      if (any_warn) begin
        warn_lat_r <= 1'b1;
      end else if (CLEAR_FAULTS_IN) begin
        warn_lat_r <= 1'b0;
      end
    end
  end

  // Alert pulls low in every mode while any flag stands
  // Kept as the active-low level so both pins come straight from this flop
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      alert_n_r <= 1'b1;
    end else begin
      alert_n_r <= ~(lo_fault_lat_r | warn_lat_r | lo_fault | any_warn);
    end
  end

  // Attempt count is cleared on every way into the retry path
  assign tries_inc = tries_r + 3'h1;
  // Forever setting never runs out of attempts
  assign retries_spent = (retry_set != `IVFR_RETRY_FOREVER) && (tries_inc >= retry_set);

  // A done left over from an abandoned count can meet a fresh start;
  // it is ignored while that start is still on its way to the timer
  assign tmr_fresh_done = core_if.tmr_done && !tmr_start_r;

  // Fault response sequencer
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= ST_OFF_CMD;
      out_en_r <= 1'b0;
      tries_r <= 3'h0;
      tmr_start_r <= 1'b0;
      tmr_retry_r <= 1'b0;
    end else begin
      tmr_start_r <= 1'b0;
      if (!OUTPUT_ON_IN || OTHER_FAULT_OFF_IN) begin
        state_r <= ST_OFF_CMD;
        out_en_r <= 1'b0;
        tries_r <= 3'h0;
      end else begin
        unique case (state_r)
          ST_OFF_CMD: begin
            // A timer still counting from before is harmless; every arm reloads it
            state_r <= ST_RUN;
            out_en_r <= 1'b1;
          end
          ST_RUN: begin
            if (lo_fault) begin
              unique case (mode)
                MODE_IGNORE: begin
                  state_r <= ST_RUN;
                end
                MODE_CONTINUE: begin
                  state_r <= ST_CONT;
                  tmr_start_r <= 1'b1;
                  tmr_retry_r <= 1'b0;
                end
                MODE_DISABLE_RETRY: begin
                  out_en_r <= 1'b0;
                  tries_r <= 3'h0;
                  if (retry_set == `IVFR_RETRY_NONE) begin
                    state_r <= ST_LATCH;
                  end else begin
                    state_r <= ST_RETRY_WAIT;
                    tmr_start_r <= 1'b1;
                    tmr_retry_r <= 1'b1;
                  end
                end
                MODE_DISABLE_CLEAR: begin
                  state_r <= ST_HOLD;
                  out_en_r <= 1'b0;
                end
              endcase
            end
          end
          ST_CONT: begin
            // Output keeps running for the whole delay; only the end decides
            if (tmr_fresh_done) begin
              if (!lo_fault) begin
                state_r <= ST_RUN;
              end else begin
                out_en_r <= 1'b0;
                tries_r <= 3'h0;
                if (retry_set == `IVFR_RETRY_NONE) begin
                  state_r <= ST_LATCH;
                end else begin
                  state_r <= ST_RETRY_WAIT;
                  tmr_start_r <= 1'b1;
                  tmr_retry_r <= 1'b1;
                end
              end
            end
          end
          ST_RETRY_WAIT: begin
            // Each expiry is one attempt; it fails at once if the fault remains
            if (tmr_fresh_done) begin
              if (!lo_fault) begin
                state_r <= ST_RUN;
                out_en_r <= 1'b1;
                tries_r <= 3'h0;
              end else if (retries_spent) begin
                state_r <= ST_LATCH;
                tries_r <= tries_inc;
              end else begin
                tries_r <= tries_inc;
                tmr_start_r <= 1'b1;
                tmr_retry_r <= 1'b1;
              end
            end
          end
          ST_HOLD: begin
            if (!lo_fault) begin
              state_r <= ST_RUN;
              out_en_r <= 1'b1;
            end
          end
          ST_LATCH: begin
            if (CLEAR_FAULTS_IN && !lo_fault) begin
              state_r <= ST_RUN;
              out_en_r <= 1'b1;
              tries_r <= 3'h0;
            end
          end
          default: begin
            state_r <= ST_OFF_CMD;
            out_en_r <= 1'b0;
            tries_r <= 3'h0;
          end
        endcase
      end
    end
  end

  assign CMD_RDATA_OUT = rdata_r;
  assign CMD_RVALID_OUT = rvalid_r;
  assign CMD_ERR_OUT = err_r;
  assign OUTPUT_ENABLE_OUT = out_en_r;
  // Open drain: the pin only ever pulls low, so value and enable share one flop
  assign ALERT_LINE_N_OUT = alert_n_r;
  assign ALERT_LINE_N_OE_N_OUT = alert_n_r;

endmodule : ivfr_input_supervisor

`default_nettype wire

// >>> ivfr_defines.svh
// Command codes, field positions, reset values and timing figures of the input-voltage supervisor
`ifndef IVFR_DEFINES_SVH
`define IVFR_DEFINES_SVH

`define IVFR_CMD_HI_WARN 8'h57
`define IVFR_CMD_LO_WARN 8'h58
`define IVFR_CMD_LO_FAULT 8'h59
`define IVFR_CMD_REACTION 8'h5A
`define IVFR_CMD_STAT_BYTE 8'h78
`define IVFR_CMD_STAT_WORD 8'h79

`define IVFR_MODE_MSB 7
`define IVFR_MODE_LSB 6
`define IVFR_RETRY_MSB 5
`define IVFR_RETRY_LSB 3
`define IVFR_DELAY_MSB 2
`define IVFR_DELAY_LSB 0

`define IVFR_RETRY_NONE 3'h0
`define IVFR_RETRY_FOREVER 3'h7

`define IVFR_SB_OFF 6
`define IVFR_SB_LO_FAULT 3
`define IVFR_SB_OTHER 0
`define IVFR_SW_INPUT 13

`define IVFR_RST_THR 16'h0000
`define IVFR_RST_REACTION 8'h00

`define IVFR_CH_HI_WARN 0
`define IVFR_CH_LO_WARN 1
`define IVFR_CH_LO_FAULT 2
`define IVFR_NUM_CH 3

`define IVFR_CLK_MHZ 100
`define IVFR_CONT_UNIT_US 10000
`define IVFR_RETRY_UNIT_US 8200
`define IVFR_PRE_W 20

`endif

// >>> ivfr_pkg.sv
// Types shared by the input-voltage supervisor modules
package ivfr_pkg;

  typedef enum logic [2:0] {
    ST_OFF_CMD = 3'h0,
    ST_RUN = 3'h1,
    ST_CONT = 3'h2,
    ST_RETRY_WAIT = 3'h3,
    ST_HOLD = 3'h4,
    ST_LATCH = 3'h5
  } ivfr_state_t;

  typedef enum logic [1:0] {
    MODE_IGNORE = 2'h0,
    MODE_CONTINUE = 2'h1,
    MODE_DISABLE_RETRY = 2'h2,
    MODE_DISABLE_CLEAR = 2'h3
  } ivfr_mode_t;

endpackage : ivfr_pkg

// >>> ivfr_core_if.sv
// Signals between the sequencer, the threshold monitor and the delay timer
`timescale 1ns/1ps
`default_nettype none
`include "ivfr_defines.svh"

interface ivfr_core_if;
  logic [15:0] vin;
  logic [`IVFR_NUM_CH-1:0][15:0] thr;
  logic [`IVFR_NUM_CH-1:0] hit;
  logic tmr_start;
  logic tmr_retry;
  logic [2:0] tmr_units;
  logic tmr_done;

  modport core (output vin, output thr, input hit,
                output tmr_start, output tmr_retry, output tmr_units, input tmr_done);
  modport mon (input vin, input thr, output hit);
  modport tmr (input tmr_start, input tmr_retry, input tmr_units, output tmr_done);
endinterface : ivfr_core_if

`default_nettype wire

// >>> ivfr_vin_monitor.sv
// Registered comparison of the measured input voltage against the three thresholds
`timescale 1ns/1ps
`default_nettype none
`include "ivfr_defines.svh"

module ivfr_vin_monitor
  import ivfr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  ivfr_core_if.mon mon
);

  genvar i;
  generate
    for (i = 0; i < `IVFR_NUM_CH; i++) begin : g_ch
      // Unsigned compare; both sides share one linear encoding
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mon.hit[i] <= 1'b0;
        end else if (i == `IVFR_CH_HI_WARN) begin
          mon.hit[i] <= (mon.vin > mon.thr[i]);
        end else begin
          mon.hit[i] <= (mon.vin < mon.thr[i]);
        end
      end
    end
  endgenerate

endmodule : ivfr_vin_monitor

`default_nettype wire

// >>> ivfr_delay_timer.sv
// Counts a number of delay units of either the continue or the retry length
`timescale 1ns/1ps
`default_nettype none
`include "ivfr_defines.svh"

module ivfr_delay_timer
  import ivfr_pkg::*;
#(
  parameter int unsigned CONT_CYC = `IVFR_CONT_UNIT_US * `IVFR_CLK_MHZ,
  parameter int unsigned RETRY_CYC = `IVFR_RETRY_UNIT_US * `IVFR_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  ivfr_core_if.tmr tmr
);

  localparam logic [`IVFR_PRE_W-1:0] CONT_LAST = `IVFR_PRE_W'(CONT_CYC - 1);
  localparam logic [`IVFR_PRE_W-1:0] RETRY_LAST = `IVFR_PRE_W'(RETRY_CYC - 1);

  logic [`IVFR_PRE_W-1:0] pre_r;
  logic [2:0] units_left_r;
  logic busy_r;
  logic retry_sel_r;
  logic unit_end;

  assign unit_end = (pre_r == (retry_sel_r ? RETRY_LAST : CONT_LAST));

  // A new start reloads the count, so the sequencer can rearm at will
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
      units_left_r <= 3'h0;
      busy_r <= 1'b0;
      retry_sel_r <= 1'b0;
      tmr.tmr_done <= 1'b0;
    end else begin
      tmr.tmr_done <= 1'b0;
      if (tmr.tmr_start) begin
        pre_r <= '0;
        units_left_r <= tmr.tmr_units;
        retry_sel_r <= tmr.tmr_retry;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (units_left_r == 3'h0) begin
          busy_r <= 1'b0;
          tmr.tmr_done <= 1'b1;
        end else if (unit_end) begin
          pre_r <= '0;
          units_left_r <= units_left_r - 3'h1;
        end else begin
          pre_r <= pre_r + `IVFR_PRE_W'(1);
        end
      end
    end
  end

endmodule : ivfr_delay_timer

`default_nettype wire

// >>> ivfr_host_model.sv
// Host model issuing command-port reads and writes
`timescale 1ns/1ps
`default_nettype none
module ivfr_host_model (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] code_out,
  output logic [15:0] data_out,
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    code_out = 8'h00;
    data_out = 16'h0000;
  end
  task automatic put(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    code_out <= c;
    data_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : put
  // Data without the valid pulse is returned as unknown so it never matches
  task automatic get(input logic [7:0] c, output logic [15:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    code_out <= c;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1;
    d = rvalid_in ? rdata_in : 16'hXXXX;
  endtask : get
endmodule : ivfr_host_model
`default_nettype wire

// >>> ivfr_input_supervisor_chk.sv
// Port-level assertions for the input-voltage supervisor
`timescale 1ns/1ps
`default_nettype none
module ivfr_input_supervisor_chk (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CMD_WR_IN,
  input wire logic CMD_RD_IN,
  input wire logic [7:0] CMD_CODE_IN,
  input wire logic [15:0] CMD_RDATA_OUT,
  input wire logic CMD_RVALID_OUT,
  input wire logic CMD_ERR_OUT,
  input wire logic OUTPUT_ON_IN,
  input wire logic OTHER_FAULT_OFF_IN,
  input wire logic CLEAR_FAULTS_IN,
  input wire logic OUTPUT_ENABLE_OUT,
  input wire logic ALERT_LINE_N_OUT,
  input wire logic ALERT_LINE_N_OE_N_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  rd_answer_a: assert property (CMD_RD_IN |=> CMD_RVALID_OUT)
    else $error("read not answered");
  no_stray_a: assert property (!CMD_RD_IN |=> !CMD_RVALID_OUT)
    else $error("valid without read");
  rdata_hold_a: assert property (!CMD_RD_IN |=> $stable(CMD_RDATA_OUT))
    else $error("read data moved");
  byte_upper_a: assert property (CMD_RD_IN && CMD_CODE_IN == 8'h5A |=>
    CMD_RDATA_OUT[15:8] == 8'h00) else $error("byte read upper not zero");
  good_write_a: assert property (CMD_WR_IN && !CMD_RD_IN &&
    CMD_CODE_IN inside {[8'h57:8'h5A]} |=> !CMD_ERR_OUT) else $error("valid write refused");
  status_wr_a: assert property (CMD_WR_IN && CMD_CODE_IN inside {8'h78, 8'h79}
    |=> CMD_ERR_OUT) else $error("status write not refused");
  bad_code_a: assert property ((CMD_RD_IN || CMD_WR_IN) &&
    !(CMD_CODE_IN inside {[8'h57:8'h5A], 8'h78, 8'h79}) |=> CMD_ERR_OUT)
    else $error("unknown code not refused");
  alert_sticky_a: assert property (!ALERT_LINE_N_OE_N_OUT &&
    !$past(CLEAR_FAULTS_IN) |=> !ALERT_LINE_N_OE_N_OUT)
    else $error("alert released without clear");
  off_cmd_a: assert property (!OUTPUT_ON_IN || OTHER_FAULT_OFF_IN |=>
    !OUTPUT_ENABLE_OUT) else $error("output on while commanded off");
  on_cause_a: assert property ($rose(OUTPUT_ENABLE_OUT) |->
    $past(OUTPUT_ON_IN) && !$past(OTHER_FAULT_OFF_IN)) else $error("output on without command");
endmodule : ivfr_input_supervisor_chk
`default_nettype wire

// >>> ivfr_testbench.sv
// Self-checking bench for the input-voltage supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr;
  logic rd;
  logic [7:0] code;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rvalid;
  logic [15:0] vin = 16'h8000;
  logic on = 1'b1;
  logic other = 1'b0;
  logic clr = 1'b0;
  logic oe;
  logic al_n;
  logic al_oe_n;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  // Short units keep continue and retry waits to tens of cycles
  ivfr_input_supervisor #(.CONT_UNIT_CYC(20), .RETRY_UNIT_CYC(16)) u_dut (
    .SYS_CLK_IN(clk), .RST_IN(rst), .CMD_WR_IN(wr), .CMD_RD_IN(rd), .CMD_CODE_IN(code),
    .CMD_WDATA_IN(wdata), .CMD_RDATA_OUT(rdata), .CMD_RVALID_OUT(rvalid), .CMD_ERR_OUT(),
    .VIN_VALUE_IN(vin), .OUTPUT_ON_IN(on), .OTHER_FAULT_OFF_IN(other),
    .CLEAR_FAULTS_IN(clr), .OUTPUT_ENABLE_OUT(oe), .ALERT_LINE_N_OUT(al_n),
    .ALERT_LINE_N_OE_N_OUT(al_oe_n));
  ivfr_host_model u_host (.clk_in(clk), .wr_out(wr), .rd_out(rd), .code_out(code),
    .data_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp, input string name);
    logic [15:0] d;
    u_host.get(c, d);
    check(name, exp, d);
  endtask : rd_chk
  task automatic chk_oe(input logic e);
    check("output enable", {15'h0000, e}, {15'h0000, oe});
  endtask : chk_oe
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic set_vin(input logic [15:0] v);
    @(posedge clk);
    vin <= v;
  endtask : set_vin
  // Command-off also clears any retry or latched state between scenarios
  task automatic restore();
    set_vin(16'h8000);
    clr <= 1'b1;
    on <= 1'b0;
    other <= 1'b1;
    cyc(3);
    @(posedge clk);
    clr <= 1'b0;
    on <= 1'b1;
    other <= 1'b0;
    cyc(4);
    chk_oe(1'b1);
    check("alert line", 16'h0001, {15'h0000, al_n});
  endtask : restore
  task automatic t_regs();
    for (int i = 0; i < 3; i++) begin
      rd_chk(8'h57 + 8'(i), 16'h0000, "threshold reset");
      u_host.put(8'h57 + 8'(i), 16'hA5C3 ^ 16'(i));
      rd_chk(8'h57 + 8'(i), 16'hA5C3 ^ 16'(i), "threshold");
    end
    u_host.put(8'h57, 16'hFFFF);
    u_host.put(8'h58, 16'h0000);
    u_host.put(8'h59, 16'h4000);
    rd_chk(8'h5A, 16'h0000, "reaction reset");
    u_host.put(8'h5A, 16'hFF52);
    rd_chk(8'h5A, 16'h0052, "reaction");
    // Fault and warning latched while the thresholds sat above the input
    u_host.put(8'h78, 16'h00FF);
    rd_chk(8'h78, 16'h0009, "status byte");
    rd_chk(8'h20, 16'h0000, "unknown code");
    restore();
  endtask : t_regs
  task automatic t_warn();
    u_host.put(8'h57, 16'h0100);
    cyc(5);
    chk_oe(1'b1);
    check("alert enable", 16'h0000, {15'h0000, al_oe_n});
    rd_chk(8'h78, 16'h0001, "status byte");
    u_host.put(8'h57, 16'hFFFF);
    restore();
  endtask : t_warn
  task automatic t_ignore();
    u_host.put(8'h5A, 16'h0000);
    set_vin(16'h1000);
    cyc(8);
    chk_oe(1'b1);
    check("alert enable", 16'h0000, {15'h0000, al_oe_n});
    check("alert line", 16'h0000, {15'h0000, al_n});
    rd_chk(8'h78, 16'h0008, "status byte");
    rd_chk(8'h79, 16'h2008, "status word");
    restore();
  endtask : t_ignore
  task automatic t_hold();
    u_host.put(8'h5A, 16'h00C0);
    set_vin(16'h1000);
    cyc(4);
    chk_oe(1'b0);
    set_vin(16'h8000);
    cyc(4);
    chk_oe(1'b1);
    restore();
  endtask : t_hold
  task automatic t_latch();
    u_host.put(8'h5A, 16'h0080);
    set_vin(16'h1000);
    cyc(2);
    chk_oe(1'b0);
    set_vin(16'h8000);
    cyc(40);
    chk_oe(1'b0);
    rd_chk(8'h78, 16'h0048, "status byte");
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    cyc(3);
    chk_oe(1'b1);
    restore();
  endtask : t_latch
  // Two retries, one delay unit apart
  task automatic t_retry();
    u_host.put(8'h5A, 16'h0091);
    set_vin(16'h1000);
    cyc(2);
    set_vin(16'h8000);
    cyc(10);
    chk_oe(1'b0);
    cyc(20);
    chk_oe(1'b1);
    restore();
    set_vin(16'h1000);
    cyc(26);
    set_vin(16'h8000);
    cyc(30);
    chk_oe(1'b1);
    restore();
    set_vin(16'h1000);
    cyc(80);
    set_vin(16'h8000);
    cyc(40);
    chk_oe(1'b0);
    restore();
  endtask : t_retry
  task automatic t_forever();
    u_host.put(8'h5A, 16'h00B8);
    set_vin(16'h1000);
    cyc(150);
    set_vin(16'h8000);
    cyc(12);
    chk_oe(1'b1);
    restore();
  endtask : t_forever
  task automatic t_cont();
    u_host.put(8'h5A, 16'h0041);
    set_vin(16'h1000);
    cyc(14);
    chk_oe(1'b1);
    cyc(18);
    chk_oe(1'b0);
    restore();
  endtask : t_cont
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    t_regs();
    t_warn();
    t_ignore();
    t_hold();
    t_latch();
    t_retry();
    t_forever();
    t_cont();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : testbench
bind ivfr_input_supervisor ivfr_input_supervisor_chk u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .CMD_WR_IN(CMD_WR_IN), .CMD_RD_IN(CMD_RD_IN),
  .CMD_CODE_IN(CMD_CODE_IN), .CMD_RDATA_OUT(CMD_RDATA_OUT), .CMD_RVALID_OUT(CMD_RVALID_OUT),
  .CMD_ERR_OUT(CMD_ERR_OUT), .OUTPUT_ON_IN(OUTPUT_ON_IN),
  .OTHER_FAULT_OFF_IN(OTHER_FAULT_OFF_IN), .CLEAR_FAULTS_IN(CLEAR_FAULTS_IN),
  .OUTPUT_ENABLE_OUT(OUTPUT_ENABLE_OUT),
  .ALERT_LINE_N_OUT(ALERT_LINE_N_OUT), .ALERT_LINE_N_OE_N_OUT(ALERT_LINE_N_OE_N_OUT));
`default_nettype wire
